/* File: src/aout_pkg.sv */
`default_nettype none
package aout_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] ctrl_off       = 12'h000;
  localparam logic [11:0] status_off     = 12'h004;
  localparam logic [11:0] irq_stat_off   = 12'h008;
  localparam logic [11:0] irq_mask_off   = 12'h00c;
  localparam logic [11:0] chan_base_off  = 12'h100;
  localparam logic [11:0] chan_stride    = 12'h020;
  localparam logic [11:0] ch_enable_off  = 12'h000;
  localparam logic [11:0] ch_gain_off    = 12'h004;
  localparam logic [11:0] ch_offset_off  = 12'h008;
  localparam logic [11:0] ch_refresh_off = 12'h00c;
  localparam logic [11:0] ch_value_off   = 12'h010;
  localparam logic [11:0] ch_high_off    = 12'h014;
  localparam logic [11:0] ch_low_off     = 12'h018;
  localparam logic [11:0] ch_drive_off   = 12'h01c;

  // Control register fields
  localparam int ctrl_run_bit    = 0;
  localparam int ctrl_retain_bit = 1;
  localparam int ctrl_float_bit  = 2;
  localparam int ctrl_minor_bit  = 3;
  localparam int ctrl_major_bit  = 4;

  // Interrupt status fields
  localparam int irq_pass_bit = 0;
  localparam int irq_stop_bit = 1;
  localparam int irq_bits     = 2;

  // Calibration and scaling
  localparam logic signed [15:0] unity_gain  = 16'sd1000;
  localparam int                 gain_div    = 1000;
  localparam logic signed [15:0] code_max    = 16'sd32000;
  localparam logic signed [15:0] code_min    = -16'sd32000;
  localparam logic signed [15:0] zero_code   = 16'sd0;
  localparam logic signed [15:0] high_default = 16'sd100;
  localparam logic signed [15:0] low_default  = -16'sd100;
  localparam logic [15:0]        refresh_default = 16'h0001;

  // Timing
  localparam int clk_mhz        = 100;
  localparam int slot_time_us   = 2000;
  localparam int slot_cycles    = slot_time_us * clk_mhz;
  localparam int blink_time_ms  = 250;
  localparam int blink_cycles   = blink_time_ms * 1000 * clk_mhz;

  typedef struct packed {
    logic run;
    logic err;
    logic conv;
  } leds_s;

  typedef enum logic [1:0] {idle, seek, convert} seq_e;

endpackage
`default_nettype wire

/* File: src/analog_output_channel_control.sv */
// How it works
// R1 - Each enabled channel gets one conversion slot of fixed 2 ms, so a pass lasts 2 ms times the enabled count.
// R2 - Each channel has an enable bit and disabled channels are skipped, shortening the pass.
// R3 - Each code is multiplied by its channel gain, divided by 1000, then offset by a signed channel value.
// R4 - With gain 1000 and offset 0 the full bipolar range maps onto codes -32000 to +32000.
// R5 - With retain selected, leaving run keeps each channel driving its last output.
// R6 - A per-channel refresh time sets the ramp slope used when that channel changes.
// R7 - A changed target is approached by at most the slope per slot, so a change within the slope is taken in one step.
// R8 - Output updates run on the same slot period as the input sampling cycle.
// R9 - In float format, values between low and high scale points map linearly onto the code range.
// R10 - The run indicator is steady on while running and off otherwise.
// R11 - The error indicator is steady for a serious error, blinks for a minor one, else off.
// R12 - The conversion indicator blinks while conversion runs and is off once stopped.
// R13 - Without retain, leaving run zeroes every channel's drive value but loads the zero code only on the last converted channel.
`timescale 1ns/1ns
`default_nettype none
module analog_output_channel_control
  import aout_pkg::*;
#(
  parameter int num_ch     = 2,
  parameter int slot_len   = slot_cycles,
  parameter int blink_len  = blink_cycles
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Converter side
  output logic [15:0]                dac_code,
  output logic [$clog2(num_ch)-1:0]  dac_chan,
  output logic                       dac_load,
  // Indicators and interrupt
  output var leds_s                  leds,
  output logic                       irq
);

  localparam int cw = $clog2(num_ch);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0]                ctrl;
  logic [irq_bits-1:0]       irq_stat;
  logic [irq_bits-1:0]       irq_mask;
  logic [num_ch-1:0]         ch_en;
  logic signed [15:0]        gain      [num_ch];
  logic signed [15:0]        offs      [num_ch];
  logic [15:0]               refresh   [num_ch];
  logic signed [15:0]        value     [num_ch];
  logic signed [15:0]        high_scale_point [num_ch];
  logic signed [15:0]        low_scale_point  [num_ch];
  logic signed [15:0]        drive     [num_ch];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire [11:0] ch_rel   = paddr - chan_base_off;
  wire [11:0] ch_idx   = ch_rel / chan_stride;
  wire [11:0] ch_reg   = ch_rel % chan_stride;
  wire        in_chan  = (paddr >= chan_base_off) && (ch_idx < 12'(num_ch));
  wire [cw-1:0] sel_ch = ch_idx[cw-1:0];
  wire        is_glob  = (paddr == ctrl_off) || (paddr == status_off) ||
                         (paddr == irq_stat_off) || (paddr == irq_mask_off);
  wire        mapped   = is_glob || in_chan;
  wire        full_wr  = wr & (pstrb[1:0] == 2'h3);

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  seq_e                   state;
  logic [cw-1:0]          cur;
  logic [31:0]            slot_cnt;
  wire                    running = ctrl[ctrl_run_bit];
  wire                    any_en  = |ch_en;
  wire                    slot_end = (slot_cnt == 32'(slot_len - 1));
  wire [cw-1:0]           nxt_ch  = (32'(cur) == 32'(num_ch - 1)) ? '0 : cw'(cur + 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= idle;
      cur      <= '0;
      slot_cnt <= '0;
    end else begin
      unique case (state)
        idle: begin
          slot_cnt <= '0;
          // Every pass starts from channel 0 after a stop
          cur      <= '0;
          if (running && any_en) begin
            state <= seek;
          end
        end
        seek: begin
          if (!running || !any_en) begin
            state <= idle;
          end else if (ch_en[cur]) begin // see R2
            state <= convert;
          end else begin
            cur <= nxt_ch; // see R2
          end
        end
        convert: begin
          slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1; // see R1
          // A stop abandons the slot so no late load follows it
          if (!running) begin
            state <= idle;
          end else if (slot_end) begin
            cur   <= nxt_ch;
            state <= seek; // see R8
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Target: float scaling then calibration
  // ----------------------------------------------------------------
  logic signed [15:0] tgt_val, tgt_high, tgt_low, tgt_gain, tgt_offs;
  assign tgt_val  = value[cur];
  assign tgt_high = high_scale_point[cur];
  assign tgt_low  = low_scale_point[cur];
  assign tgt_gain = gain[cur];
  assign tgt_offs = offs[cur];

  // Span guarded so a zero span cannot divide by zero
  wire signed [31:0] span   = 32'(tgt_high) - 32'(tgt_low);
  wire signed [31:0] safe_sp = (span == 0) ? 32'sd1 : span;
  // Full code span widened first: it does not fit 16 bits
  wire signed [31:0] full_sp = 32'(code_max) - 32'(code_min);
  wire signed [31:0] scaled = ((32'(tgt_val) - 32'(tgt_low)) * full_sp)
                              / safe_sp + 32'(code_min); // see R9
  wire signed [31:0] raw    = ctrl[ctrl_float_bit] ? scaled : 32'(tgt_val); // see R4
  wire signed [31:0] cal    = (raw * 32'(tgt_gain)) / gain_div + 32'(tgt_offs); // see R3
  wire signed [15:0] target = (cal > 32'(code_max)) ? code_max :
                              (cal < 32'(code_min)) ? code_min : cal[15:0];

  // Slope: full span over refresh slots, zero refresh taken as one; above 64000 slots the slope is zero
  wire [15:0]        rf     = (refresh[cur] == 16'h0) ? 16'h1 : refresh[cur];
  wire signed [31:0] slope  = 32'((32'(code_max) - 32'(code_min)) / 32'(rf)); // see R6
  wire signed [31:0] now    = 32'(drive[cur]);
  wire signed [31:0] diff   = 32'(target) - now;
  wire signed [31:0] stepped = (diff > slope) ? now + slope :
                               (-diff > slope) ? now - slope : 32'(target); // see R7

  // ----------------------------------------------------------------
  // Stop handling
  // ----------------------------------------------------------------
  logic run_d;
  wire  stop_evt = run_d & ~running;
  wire  pass_evt = (state == convert) && slot_end && (nxt_ch == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d <= 1'b0;
    end else begin
      run_d <= running;
    end
  end

  // Drive values per channel
  genvar g;
  generate
    for (g = 0; g < num_ch; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drive[g] <= zero_code;
        end else if (stop_evt && !ctrl[ctrl_retain_bit]) begin
          drive[g] <= zero_code; // see R13
        end else if (state == convert && slot_end && 32'(cur) == g) begin
          drive[g] <= stepped[15:0]; // see R7
        end
      end
    end
  endgenerate

  // Converter output; retained codes hold because stop_flush stays low with retain set, so no zero load is issued (see R5)
  logic stop_flush;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code   <= '0;
      dac_chan   <= '0;
      dac_load   <= 1'b0;
      stop_flush <= 1'b0;
    end else begin
      stop_flush <= stop_evt & ~ctrl[ctrl_retain_bit];
      dac_load   <= (state == convert && slot_end) || stop_flush;
      if (state == convert && slot_end) begin
        dac_code <= stepped[15:0];
        dac_chan <= cur;
      end else if (stop_flush) begin
        dac_code <= zero_code; // see R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt;
  logic        blink;
  logic        minor_q;
  wire         blink_wrap = (blink_cnt == 32'(blink_len - 1));

  // Minor flag taken only at a toggle, so no blink phase is cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
      minor_q   <= 1'b0;
      leds      <= '0;
    end else begin
      blink_cnt <= blink_wrap ? '0 : blink_cnt + 1'b1;
      if (blink_wrap) begin
        blink   <= ~blink;
        minor_q <= ctrl[ctrl_minor_bit];
      end
      leds.run  <= running; // see R10
      leds.err  <= ctrl[ctrl_major_bit] | (minor_q & blink); // see R11
      leds.conv <= (state != idle) & blink; // see R12
    end
  end

  // ----------------------------------------------------------------
  // Register writes and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= '0;
      irq_mask <= '0;
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      if (full_wr && paddr == ctrl_off) begin
        ctrl <= pwdata[4:0];
      end
      if (full_wr && paddr == irq_mask_off) begin
        irq_mask <= pwdata[irq_bits-1:0];
      end
      // Set wins over a same-cycle clear
      irq_stat <= (irq_stat & ~((full_wr && paddr == irq_stat_off) ?
                   pwdata[irq_bits-1:0] : '0)) |
                  {stop_evt, pass_evt};
      irq      <= |(irq_stat & irq_mask);
    end
  end

  generate
    for (g = 0; g < num_ch; g++) begin : g_cfg
      wire hit = full_wr && in_chan && 32'(sel_ch) == g;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_en[g]   <= 1'b0;
          gain[g]    <= unity_gain;
          offs[g]    <= zero_code;
          refresh[g] <= refresh_default;
          value[g]   <= zero_code;
          high_scale_point[g] <= high_default;
          low_scale_point[g]  <= low_default;
        end else if (hit) begin
          if (ch_reg == ch_enable_off)  ch_en[g]   <= pwdata[0]; // see R2
          if (ch_reg == ch_gain_off)    gain[g]    <= pwdata[15:0]; // see R3
          if (ch_reg == ch_offset_off)  offs[g]    <= pwdata[15:0]; // see R3
          if (ch_reg == ch_refresh_off) refresh[g] <= pwdata[15:0]; // see R6
          if (ch_reg == ch_value_off)   value[g]   <= pwdata[15:0];
          if (ch_reg == ch_high_off)    high_scale_point[g] <= pwdata[15:0]; // see R9
          if (ch_reg == ch_low_off)     low_scale_point[g]  <= pwdata[15:0]; // see R9
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    if (paddr == ctrl_off)          rd = {27'h0, ctrl};
    else if (paddr == status_off)   rd = {24'h0, 4'(cur), 2'(state), 1'b0, running};
    else if (paddr == irq_stat_off) rd = {30'h0, irq_stat};
    else if (paddr == irq_mask_off) rd = {30'h0, irq_mask};
    else if (in_chan) begin
      if (ch_reg == ch_enable_off)       rd = {31'h0, ch_en[sel_ch]};
      else if (ch_reg == ch_gain_off)    rd = {{16{gain[sel_ch][15]}}, gain[sel_ch]};
      else if (ch_reg == ch_offset_off)  rd = {{16{offs[sel_ch][15]}}, offs[sel_ch]};
      else if (ch_reg == ch_refresh_off) rd = {16'h0, refresh[sel_ch]};
      else if (ch_reg == ch_value_off)   rd = {{16{value[sel_ch][15]}}, value[sel_ch]};
      else if (ch_reg == ch_high_off)
        rd = {{16{high_scale_point[sel_ch][15]}}, high_scale_point[sel_ch]};
      else if (ch_reg == ch_low_off)
        rd = {{16{low_scale_point[sel_ch][15]}}, low_scale_point[sel_ch]};
      else                               rd = {{16{drive[sel_ch][15]}}, drive[sel_ch]};
    end
  end

  // No wait state: answer registered at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rd : '0;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

endmodule
`default_nettype wire

/* File: sim/aout_props.sv */
`timescale 1ns/1ns
`default_nettype none
module aout_props
  import aout_pkg::*;
#(
  parameter int num_ch    = 2,
  parameter int slot_len  = 20,
  parameter int blink_len = 4
) (
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // Register bus
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic                      pready,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  // Converter, indicators, interrupt
  input wire logic [15:0]               dac_code,
  input wire logic [$clog2(num_ch)-1:0] dac_chan,
  input wire logic                      dac_load,
  input wire leds_s                     leds,
  input wire logic                      irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_CAUSE: assert property ((psel && !penable) |=> pready)
    else $error("setup cycle not answered");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_SLVERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without answer");
  AST_LOAD_PULSE: assert property (dac_load |=> !dac_load)
    else $error("load longer than one cycle");
  AST_CODE_HOLD: assert property (!dac_load |-> $stable(dac_code) && $stable(dac_chan))
    else $error("code moved between loads");
  AST_RUN_LED: assert property ($rose(leds.run) |->
    $past(pwrite && penable && pready) || $past(pwrite && penable && pready, 2))
    else $error("run light without a write");
  AST_ERR_BLINK: assert property ($rose(leds.err) |=> leds.err [*3])
    else $error("error light phase too short");
endmodule
bind analog_output_channel_control aout_props #(
  .num_ch(num_ch), .slot_len(slot_len), .blink_len(blink_len)
) aout_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .dac_code(dac_code), .dac_chan(dac_chan), .dac_load(dac_load),
  .leds(leds), .irq(irq)
);
`default_nettype wire

/* File: sim/dac_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_model #(
  parameter int num_ch = 2
) (
  // Clock and converter side
  input wire logic                      pclk,
  input wire logic [15:0]               dac_code,
  input wire logic [$clog2(num_ch)-1:0] dac_chan,
  input wire logic                      dac_load
);
  // Every load is kept so none is lost while the bench is busy on the bus
  logic [15:0] code_q[$];
  int          chan_q[$];
  always @(posedge pclk) begin
    if (dac_load === 1'b1) begin
      code_q.push_back(dac_code);
      chan_q.push_back(int'(dac_chan));
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_analog_output_channel_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_analog_output_channel_control
  import aout_pkg::*;
;
  localparam int sl = 20;
  localparam int bl = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dac_load, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [15:0] dac_code;
  logic [0:0]  dac_chan;
  logic [1:0]  hi, lo;
  leds_s       leds;
  int          fail_count, n_compared, lc, hi_pt, lo_pt, fl;
  int          drv[2], gain[2], offs[2], val[2], refr[2], en[2];
  analog_output_channel_control #(.num_ch(2), .slot_len(sl), .blink_len(bl))
    analog_output_channel_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .dac_code(dac_code),
    .dac_chan(dac_chan), .dac_load(dac_load), .leds(leds), .irq(irq));
  dac_model #(.num_ch(2)) dac_model_i (.pclk(pclk), .dac_code(dac_code),
    .dac_chan(dac_chan), .dac_load(dac_load));
  // --------
  // Bus and compare tasks
  // --------
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic ex, input logic got);
    n_compared++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, ex, got);
    end
  endtask
  // Waits for pready however long it takes, up to a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, 32'(d), 4'hf);
  endtask
  function automatic logic [11:0] ca(input int c, input logic [11:0] o);
    return chan_base_off + 12'(c) * chan_stride + o;
  endfunction
  task automatic cfg(input int c);
    wr(ca(c, ch_enable_off), en[c]);
    wr(ca(c, ch_gain_off), gain[c]);
    wr(ca(c, ch_offset_off), offs[c]);
    wr(ca(c, ch_refresh_off), refr[c]);
    wr(ca(c, ch_value_off), val[c]);
  endtask
  // --------
  // Reference model of the output path
  // --------
  function automatic int target(input int c);
    int t;
    t = val[c];
    if (fl != 0) t = (val[c] - lo_pt) * 64000 / (hi_pt - lo_pt) - 32000;
    t = t * gain[c] / 1000 + offs[c];
    return t > 32000 ? 32000 : (t < -32000 ? -32000 : t);
  endfunction
  task automatic take_loads(input int k);
    int t, st, c, n;
    repeat (k) begin
      n = 0;
      while (dac_model_i.code_q.size() == 0 && n < 8 * sl) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 8 * sl) fail_count++;
      c = (lc < 1 && en[lc + 1] != 0) ? lc + 1 : (en[0] != 0 ? 0 : 1);
      lc = c;
      t = target(c);
      st = 64000 / refr[c];
      drv[c] = t > drv[c] ? (drv[c] + st > t ? t : drv[c] + st) : (drv[c] - st < t ? t : drv[c] - st);
      chk_word("dac_chan", 32'(c), 32'(dac_model_i.chan_q.pop_front()));
      chk_word("dac_code", 32'(drv[c]), 32'(signed'(dac_model_i.code_q.pop_front())));
    end
  endtask
  task automatic stop_chk();
    repeat (10) @(posedge pclk);
    chk_word("stop code", 32'h0, 32'(dac_model_i.code_q[$]));
    chk_bit("run light", 1'b0, leds.run);
    dac_model_i.code_q.delete();
    dac_model_i.chan_q.delete();
    drv = '{0, 0};
  endtask
  // --------
  // Stimulus
  // --------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    void'($urandom(32'h1f6995b7));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ca(1, ch_low_off), 32'h0, 4'hf);
    chk_word("lsp reset", 32'hffffff9c, r);
    apb(1'b0, ca(0, ch_refresh_off), 32'h0, 4'hf);
    chk_word("refresh reset", 32'h1, r);
    apb(1'b0, 12'hff0, 32'h0, 4'hf);
    chk_bit("unmapped error", 1'b1, e);
    apb(1'b1, ca(0, ch_gain_off), 32'h5, 4'b1100);
    apb(1'b0, ca(0, ch_gain_off), 32'h0, 4'hf);
    chk_word("partial write", 32'd1000, r);
    for (int c = 0; c < 2; c++) begin
      gain[c] = 500 + int'($urandom % 1001);
      offs[c] = int'($urandom % 1001) - 500;
      val[c] = int'($urandom % 16001) - 8000;
      refr[c] = 1;
      en[c] = 1;
    end
    {gain[1], offs[1], val[1], refr[1], hi_pt, lo_pt, fl, lc} = {32'd1000, 32'd0, 32'd30000, 32'd4,
                                                             32'd100, -32'd100, 32'd0, -32'd1};
    drv = '{0, 0};
    cfg(0);
    cfg(1);
    wr(irq_mask_off, 1);
    wr(ctrl_off, 1);
    take_loads(4);
    apb(1'b0, ca(1, ch_drive_off), 32'h0, 4'hf);
    chk_word("drive", 32'(drv[1]), r);
    chk_bit("run light", 1'b1, leds.run);
    chk_bit("irq", 1'b1, irq);
    wr(irq_mask_off, 0);
    @(posedge pclk);
    chk_bit("irq masked", 1'b0, irq);
    wr(ctrl_off, 0);
    stop_chk();
    {en[0], val[1], lc} = {32'd0, -32'd20000, -32'd1};
    cfg(0);
    cfg(1);
    wr(ctrl_off, 3);
    take_loads(3);
    wr(ctrl_off, 2);
    repeat (5) @(posedge pclk);
    dac_model_i.code_q.delete();
    repeat (3 * sl) @(posedge pclk);
    chk_word("loads held", 32'h0, 32'(dac_model_i.code_q.size()));
    apb(1'b0, ca(1, ch_drive_off), 32'h0, 4'hf);
    chk_word("retained", 32'(drv[1]), r);
    dac_model_i.chan_q.delete();
    {val[1], fl, lc} = {32'd50, 32'd1, -32'd1};
    cfg(1);
    wr(ctrl_off, 13);
    take_loads(3);
    {hi, lo} = '0;
    repeat (4 * bl) begin
      @(posedge pclk);
      hi |= {leds.err, leds.conv};
      lo |= ~{leds.err, leds.conv};
    end
    chk_word("blinking", 32'h3, 32'(hi & lo));
    wr(ctrl_off, 16);
    stop_chk();
    chk_bit("err steady", 1'b1, leds.err);
    chk_bit("conv off", 1'b0, leds.conv);
    report_and_stop();
  end
endmodule
`default_nettype wire
